// ==== pkg/czx_pkg.sv ====
/*
  Shared constants and types for the channel 0 extraction command block.
  Assumes eight PCM buses and one system clock at 25 MHz.
*/
package czx_pkg;
  // ==========================================================
  // Sizes
  localparam int BUSES  = 8;
  localparam int BUS_W  = 3;
  localparam int WORD_W = 11;

  // ==========================================================
  // Codes and reset values
  localparam logic [3:0] OPC_MASK   = 4'he;
  localparam logic [3:0] STAT_TAIL  = 4'he;
  localparam logic [1:0] LABEL_IDLE = 2'h1;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] RDATA_RST  = 8'h00;
  localparam logic [7:0] STAT_RST   = 8'h0e;
  localparam logic [3:0] CNT_DONE   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FIRST = 3'b001,
    ST_LOAD  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_XFER  = 3'b100
  } czx_state_e;
endpackage

// ==== pkg/czx_stream_if.sv ====
/*
  Valid/ready word channel between the capture logic, the buffer and memory.
  Assumes all users share one clock.
*/
`timescale 1ns/1ps
interface czx_stream_if #(parameter int W = 11);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/czx_mem.sv ====
/*
  Small captured-byte store, one word per PCM bus, registered read data.
  Assumes write and read are never requested in the same cycle.
*/
`timescale 1ns/1ps
module czx_mem #(
  parameter int AW = 3,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;

  // ==========================================================
  // Read register
  always_comb begin
    rdata_nxt = re_i ? mem_r[addr_i] : rdata_r;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Array, no reset: contents are only read after a write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = rdata_r;
endmodule

// ==== verilog/czx_buf2.sv ====
/*
  Two-entry valid/ready buffer.
  Assumes the drain side may hold ready low for any number of cycles.
*/
`timescale 1ns/1ps
module czx_buf2 #(
  parameter int W = 11
) (
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  czx_stream_if.snk  in_s,
  czx_stream_if.src  out_s
);
  logic [W-1:0] d0_r, d0_nxt;
  logic [W-1:0] d1_r, d1_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         push;
  logic         pop;

  assign in_s.ready  = (cnt_r != 2'h2);
  assign out_s.valid = (cnt_r != 2'h0);
  assign out_s.data  = d0_r;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // ==========================================================
  // Occupancy and entries
  always_comb begin
    d0_nxt  = d0_r;
    d1_nxt  = d1_r;
    cnt_nxt = cnt_r;
    if (pop && !push) begin
      d0_nxt  = d1_r;
      cnt_nxt = cnt_r - 2'h1;
    end else if (push && !pop) begin
      if (cnt_r == 2'h0) begin
        d0_nxt = in_s.data;
      end else begin
        d1_nxt = in_s.data;
      end
      cnt_nxt = cnt_r + 2'h1;
    end else if (push && pop) begin
      d0_nxt = in_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      d0_r  <= '0;
      d1_r  <= '0;
      cnt_r <= 2'h0;
    end else begin
      d0_r  <= d0_nxt;
      d1_r  <= d1_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== verilog/czx_top.sv ====
/*
  Channel 0 selection mask store and extracted-message readback.
  Assumes host strobes, bit clock, frame sync and PCM lines are synchronous to clk_i.
*/
// Notes on behaviour
// R1: Host writes mask high three bits, then low five, then the opcode.
// R2: Second data byte bits 4..0 become the low five mask bits.
// R3: A set mask bit enables extraction on its bus, clear disables.
// R4: Zero mask or reset clears mask and pending state, disables extraction.
// R5: Only a non-zero mask write activates extraction; status read optional.
// R6: After mask store and first step, data readback keeps old contents.
// R7: Store status: active count in 7..5, active flag in 4, tail 1110. The code shows a count of eight as 000.
// R8: First status after ready: pending count, flag always one, tail 1110. The code shows a count of eight as 000.
// R9: Host reads status after ready to advance each step.
// R10: Host reads data each step; buses are scanned highest first.
// R11: Later steps return the stored channel 0 byte in data readback.
// R12: Only bytes whose top two label bits differ from 01 are taken.
// R13: Later status bits 7..5 name the source bus; tail 1110.
// R14: Later status bit 4 says whether more steps remain.
// R15: Frames hold N eight-bit channels; only channel 0 is captured here.
// R16: Frame sync rise marks the first bit clock of channel 0.
// R17: Shortened frames: host names input channel N-1 as 31.
// R18: Shortened frames: host names output channel 0 as N.
// R19: Returned bytes carry the first serial bit on data line 7.
// R20: Ready output stays low from a pending message until the walk ends.
`timescale 1ns/1ps
module czx_top
  import czx_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             bit_clock_i,
  input  wire logic             frame_sync_i,
  input  wire logic [BUSES-1:0] pcm_i,
  input  wire logic             cmd_sel_i,
  input  wire logic             cs_n_i,
  input  wire logic             wr_n_i,
  input  wire logic             rd_n_i,
  input  wire logic [7:0]       data_i,
  output logic      [7:0]       data_o,
  output logic                  data_oe_o,
  output logic                  extract_ready_n_o
);
  // ==========================================================
  // Helpers
  function automatic logic [BUS_W-1:0] pop_count(input logic [BUSES-1:0] v);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < BUSES; i++) begin
      s = s + {3'h0, v[i]};
    end
    return s[BUS_W-1:0];
  endfunction

  function automatic logic [BUS_W-1:0] high_idx(input logic [BUSES-1:0] v);
    logic [BUS_W-1:0] r;
    r = '0;
    for (int i = 0; i < BUSES; i++) begin
      if (v[i]) begin
        r = BUS_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [BUS_W-1:0] low_idx(input logic [BUSES-1:0] v);
    logic [BUS_W-1:0] r;
    r = '0;
    for (int i = BUSES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = BUS_W'(i);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Declarations
  czx_stream_if #(.W(WORD_W)) cap_s ();
  czx_stream_if #(.W(WORD_W)) mem_s ();

  logic             wr_prev_r, wr_prev_nxt;
  logic             rd_prev_r, rd_prev_nxt;
  logic             rd_cd_r,   rd_cd_nxt;
  logic [7:0]       last_r,    last_nxt;
  logic [7:0]       prev_r,    prev_nxt;
  logic [7:0]       dout_r,    dout_nxt;
  logic             oe_r,      oe_nxt;
  logic             wr_act, rd_act, wr_start, rd_end;
  logic             opcode_wr, or2_step;
  logic [7:0]       mask_new;

  czx_state_e       state_r,   state_nxt;
  logic [7:0]       mask_r,    mask_nxt;
  logic [BUSES-1:0] pend_r,    pend_nxt;
  logic [BUSES-1:0] snap_r,    snap_nxt;
  logic [7:0]       status_r,  status_nxt;
  logic [7:0]       rdata_r,   rdata_nxt;
  logic             ready_n_r, ready_n_nxt;
  logic [BUS_W-1:0] top_bus;
  logic             mem_rd, mem_fire;
  logic [BUS_W-1:0] mem_addr;
  logic [7:0]       mem_rdata;

  logic             bclk_prev_r, bclk_prev_nxt;
  logic             sync_prev_r, sync_prev_nxt;
  logic             arm_r,       arm_nxt;
  logic [3:0]       cnt_r,       cnt_nxt;
  logic [7:0]       cap_r   [BUSES];
  logic [7:0]       cap_nxt [BUSES];
  logic [BUSES-1:0] push_r,      push_nxt;
  logic             bclk_rise, sync_rise, cap_fire;
  logic [BUS_W-1:0] push_idx;

  // ==========================================================
  // Host port: strobes act on start of write, end of read
  assign wr_act    = !cs_n_i && !wr_n_i;
  assign rd_act    = !cs_n_i && !rd_n_i;
  assign wr_start  = wr_act && !wr_prev_r;
  assign rd_end    = !rd_act && rd_prev_r;
  assign opcode_wr = wr_start && cmd_sel_i && (data_i[3:0] == OPC_MASK);
  assign or2_step  = rd_end && rd_cd_r;
  assign mask_new  = {prev_r[2:0], last_r[4:0]}; // R1 R2

  always_comb begin
    wr_prev_nxt = wr_act;
    rd_prev_nxt = rd_act;
    rd_cd_nxt   = rd_act ? cmd_sel_i : rd_cd_r;
    last_nxt    = last_r;
    prev_nxt    = prev_r;
    if (wr_start && !cmd_sel_i) begin
      prev_nxt = last_r;
      last_nxt = data_i;
    end
    // Side effects wait for the end of a read so the byte stays stable
    dout_nxt = rd_act ? (cmd_sel_i ? status_r : rdata_r) : dout_r;
    oe_nxt   = rd_act;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
      rd_cd_r   <= 1'b0;
      last_r    <= 8'h00;
      prev_r    <= 8'h00;
      dout_r    <= 8'h00;
      oe_r      <= 1'b0;
    end else begin
      wr_prev_r <= wr_prev_nxt;
      rd_prev_r <= rd_prev_nxt;
      rd_cd_r   <= rd_cd_nxt;
      last_r    <= last_nxt;
      prev_r    <= prev_nxt;
      dout_r    <= dout_nxt;
      oe_r      <= oe_nxt;
    end
  end

  assign data_o    = dout_r;
  assign data_oe_o = oe_r;

  // ==========================================================
  // Extraction sequencer
  assign top_bus     = high_idx(snap_r); // R10
  assign mem_rd      = (state_r == ST_LOAD);
  assign mem_s.ready = !mem_rd;
  assign mem_fire    = mem_s.valid && mem_s.ready;
  assign mem_addr    = mem_rd ? top_bus : mem_s.data[WORD_W-1:8];

  always_comb begin
    state_nxt  = state_r;
    mask_nxt   = mask_r;
    pend_nxt   = pend_r;
    snap_nxt   = snap_r;
    status_nxt = status_r;
    rdata_nxt  = rdata_r; // R6
    if (opcode_wr) begin
      mask_nxt   = mask_new;
      status_nxt = {pop_count(mask_new), |mask_new, STAT_TAIL}; // R7
      if (mask_new == MASK_RST) begin
        pend_nxt  = '0; // R4
        snap_nxt  = '0;
        state_nxt = ST_IDLE;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Start only once the frame's captures are all stored, so one walk scans them in order
          if ((|pend_r) && (|mask_r) && !cap_s.valid && !mem_s.valid) begin // R5 R10
            snap_nxt   = pend_r;
            pend_nxt   = '0;
            status_nxt = {pop_count(pend_r), 1'b1, STAT_TAIL}; // R8
            state_nxt  = ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (or2_step) begin // R9
            state_nxt = ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_nxt = ST_WAIT;
        end
        ST_WAIT: begin
          rdata_nxt            = mem_rdata; // R11
          snap_nxt[top_bus]    = 1'b0;
          status_nxt[7:5]      = top_bus; // R13
          status_nxt[4]        = |(snap_r & ~(BUSES'(1) << top_bus)); // R14
          status_nxt[3:0]      = STAT_TAIL;
          state_nxt            = ST_XFER;
        end
        ST_XFER: begin
          if (or2_step) begin
            state_nxt = (|snap_r) ? ST_LOAD : ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    // A capture landing in a mask-write cycle follows the new mask, so a zero mask drops it
    if (mem_fire && mask_nxt[mem_s.data[WORD_W-1:8]]) begin
      pend_nxt[mem_s.data[WORD_W-1:8]] = 1'b1; // R3
    end
    ready_n_nxt = (state_nxt == ST_IDLE); // R20
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r   <= ST_IDLE;
      mask_r    <= MASK_RST; // R4
      pend_r    <= '0;
      snap_r    <= '0;
      status_r  <= STAT_RST;
      rdata_r   <= RDATA_RST;
      ready_n_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      mask_r    <= mask_nxt;
      pend_r    <= pend_nxt;
      snap_r    <= snap_nxt;
      status_r  <= status_nxt;
      rdata_r   <= rdata_nxt;
      ready_n_r <= ready_n_nxt;
    end
  end

  assign extract_ready_n_o = ready_n_r;

  // ==========================================================
  // Channel 0 capture: frame length beyond slot 0 is not tracked
  assign bclk_rise  = bit_clock_i && !bclk_prev_r;
  assign sync_rise  = frame_sync_i && !sync_prev_r;
  assign push_idx   = low_idx(push_r);
  assign cap_s.valid = |push_r;
  assign cap_s.data  = {push_idx, cap_r[push_idx]};
  assign cap_fire    = cap_s.valid && cap_s.ready;

  always_comb begin
    bclk_prev_nxt = bit_clock_i;
    sync_prev_nxt = frame_sync_i;
    arm_nxt       = arm_r;
    cnt_nxt       = cnt_r;
    cap_nxt       = cap_r;
    push_nxt      = push_r;
    if (cap_fire) begin
      push_nxt[push_idx] = 1'b0;
    end
    if (sync_rise) begin
      arm_nxt = 1'b1;
    end
    if (bclk_rise && (arm_r || sync_rise || (cnt_r < CNT_DONE))) begin
      for (int b = 0; b < BUSES; b++) begin
        cap_nxt[b] = {cap_r[b][6:0], pcm_i[b]}; // R19
      end
      cnt_nxt = (arm_r || sync_rise) ? 4'h1 : cnt_r + 4'h1; // R16
      arm_nxt = 1'b0;
      if (cnt_nxt == CNT_DONE) begin // R15
        for (int b = 0; b < BUSES; b++) begin
          push_nxt[b] = mask_r[b] && (cap_nxt[b][7:6] != LABEL_IDLE); // R12
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bclk_prev_r <= 1'b0;
      sync_prev_r <= 1'b0;
      arm_r       <= 1'b0;
      cnt_r       <= CNT_DONE;
      push_r      <= '0;
      for (int b = 0; b < BUSES; b++) begin
        cap_r[b] <= 8'h00;
      end
    end else begin
      bclk_prev_r <= bclk_prev_nxt;
      sync_prev_r <= sync_prev_nxt;
      arm_r       <= arm_nxt;
      cnt_r       <= cnt_nxt;
      push_r      <= push_nxt;
      cap_r       <= cap_nxt;
    end
  end

  // ==========================================================
  // Buffer and store; buffer stalls while memory is being read
  czx_buf2 #(.W(WORD_W)) u_buf (
    .clk_i  (clk_i),
    .reset_i(reset_i),
    .in_s   (cap_s),
    .out_s  (mem_s)
  );

  czx_mem #(.AW(BUS_W), .DW(8)) u_mem (
    .clk_i  (clk_i),
    .reset_i(reset_i),
    .we_i   (mem_fire),
    .re_i   (mem_rd),
    .addr_i (mem_addr),
    .wdata_i(mem_s.data[7:0]),
    .rdata_o(mem_rdata)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_first_step;
    state_r == ST_FIRST && or2_step && !opcode_wr;
  endsequence
  sequence s_load_walk;
    state_r == ST_LOAD ##1 state_r == ST_WAIT ##1 state_r == ST_XFER;
  endsequence

  a_mask_load: assert property (opcode_wr |=> mask_r == $past(mask_new)) // R2
    else $error("mask not taken from data bytes");
  a_zero_mask: assert property (opcode_wr && mask_new == 8'h00 |=> pend_r == '0 && extract_ready_n_o) // R4
    else $error("zero mask did not clear");
  a_store_status: assert property (opcode_wr |=> status_r[4] == |mask_r && status_r[3:0] == 4'he) // R7
    else $error("store status wrong");
  a_store_hold: assert property (opcode_wr |=> $stable(rdata_r)) // R6
    else $error("data readback changed on store");
  a_first_flag: assert property (state_r == ST_FIRST |-> status_r[4] || $past(opcode_wr)) // R8
    else $error("first status flag not set");
  a_step_walk: assert property (s_first_step |=> s_load_walk) // R9
    else $error("step walk out of order");
  a_more_flag: assert property (state_r == ST_WAIT ##1 !$past(opcode_wr) |-> status_r[4] == |snap_r) // R14
    else $error("continuation flag wrong");
  a_label_filter: assert property (cap_fire |-> cap_s.data[7:6] != 2'h1) // R12
    else $error("idle label captured");
  a_ready_low: assert property (state_r != ST_IDLE |-> !extract_ready_n_o) // R20
    else $error("ready high during walk");
  a_tail_fixed: assert property (state_r == ST_XFER |-> status_r[3:0] == 4'he) // R13
    else $error("status tail wrong");
endmodule

// ==== tb/czx_host_model.sv ====
/*
  Host processor model for the parallel command/data port.
  Assumes a shared clk_i; every strobe changes just after a rising edge.
*/
`timescale 1ns/1ps
module czx_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rdata_oe_i,
  output logic            cmd_sel_o,
  output logic            cs_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic [7:0]      wdata_o
);
  // ==========================================================
  // Idle levels
  initial begin
    cmd_sel_o = 1'b0;
    cs_n_o    = 1'b1;
    wr_n_o    = 1'b1;
    rd_n_o    = 1'b1;
    wdata_o   = 8'h00;
  end

  // ==========================================================
  // Bus cycles
  // One idle cycle after each write so the next strobe is seen as new
  task automatic host_write(input logic c, input logic [7:0] d);
    @(posedge clk_i);
    cmd_sel_o <= c;
    cs_n_o    <= 1'b0;
    wr_n_o    <= 1'b0;
    wdata_o   <= d;
    @(posedge clk_i);
    cs_n_o    <= 1'b1;
    wr_n_o    <= 1'b1;
    wdata_o   <= ~d;
    @(posedge clk_i);
  endtask

  // Released bus keeps a stale copy of the byte; only the enable drops
  task automatic host_read(input logic c, output logic [7:0] v, output logic oe);
    @(posedge clk_i);
    cmd_sel_o <= c;
    cs_n_o    <= 1'b0;
    rd_n_o    <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    v = rdata_i;
    oe = rdata_oe_i;
    cs_n_o    <= 1'b1;
    rd_n_o    <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule

// ==== tb/czx_top_test.sv ====
/*
  Self-checking bench for the channel 0 extraction block.
  Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
  end \
end
module czx_top_test;
  import czx_pkg::*;
  logic             clk_i        = 1'b0;
  logic             reset_i      = 1'b1;
  logic             bit_clock_i  = 1'b0;
  logic             frame_sync_i = 1'b0;
  logic [BUSES-1:0] pcm_i        = 8'h00;
  logic             cmd_sel;
  logic             cs_n;
  logic             wr_n;
  logic             rd_n;
  logic [7:0]       data_i;
  logic [7:0]       data_o;
  logic             data_oe_o;
  logic             extract_ready_n_o;
  int               miscompares  = 0;
  int               compares     = 0;
  logic [7:0]       rv;
  logic             oe;
  // Bus 7 down to bus 0; 6, 3, 2 are masked off, 5 and 0 carry the idle label
  localparam logic [63:0] FRAME = 64'hc3ff418000993c55;

  always #20 clk_i = ~clk_i;

  czx_top dut (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .bit_clock_i      (bit_clock_i),
    .frame_sync_i     (frame_sync_i),
    .pcm_i            (pcm_i),
    .cmd_sel_i        (cmd_sel),
    .cs_n_i           (cs_n),
    .wr_n_i           (wr_n),
    .rd_n_i           (rd_n),
    .data_i           (data_i),
    .data_o           (data_o),
    .data_oe_o        (data_oe_o),
    .extract_ready_n_o(extract_ready_n_o)
  );

  czx_host_model host (
    .clk_i     (clk_i),
    .rdata_i   (data_o),
    .rdata_oe_i(data_oe_o),
    .cmd_sel_o (cmd_sel),
    .cs_n_o    (cs_n),
    .wr_n_o    (wr_n),
    .rd_n_o    (rd_n),
    .wdata_o   (data_i)
  );

  // ==========================================================
  // Shared steps
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic c, input logic [7:0] exp, input string nm);
    host.host_read(c, rv, oe);
    `CHK("data_oe_o", 1'b1, oe)
    `CHK(nm, exp, rv)
  endtask

  // Junk in the unused upper bits must be ignored
  task automatic store_mask(input logic [7:0] m);
    host.host_write(1'b0, {5'h1f, m[7:5]});
    host.host_write(1'b0, {3'h7, m[4:0]});
    host.host_write(1'b1, 8'hae);
  endtask

  // Channel 0 then channel 1 (inverted bytes); clock stands still after
  // Shortened frame; the host names no channel, so no renumbering is owed
  task automatic send_frame(input logic [63:0] by);
    logic [BUSES-1:0] bits;
    for (int i = 0; i < 16; i++) begin
      for (int b = 0; b < BUSES; b++) begin
        bits[b] = (i < 8) ? by[b*8 + 7 - i] : ~by[b*8 + 15 - i];
      end
      @(posedge clk_i);
      bit_clock_i  <= 1'b1;
      frame_sync_i <= (i == 0);
      pcm_i        <= bits;
      repeat (2) @(posedge clk_i);
      bit_clock_i  <= 1'b0;
    end
    @(posedge clk_i);
    pcm_i <= ~bits;
  endtask

  task automatic wait_ready(input logic exp, input int n);
    for (int i = 0; i < n && extract_ready_n_o !== exp; i++) @(posedge clk_i);
    `CHK("extract_ready_n_o", exp, extract_ready_n_o)
  endtask

  task automatic hold_high(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge clk_i);
      if (extract_ready_n_o !== 1'b1) ok = 1'b0;
    end
    `CHK("ready held high", 1'b1, ok)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK("extract_ready_n_o", 1'b1, extract_ready_n_o)
    `CHK("data_oe_o idle", 1'b0, data_oe_o)
    rd_chk(1'b1, STAT_RST, "status after reset");
    rd_chk(1'b0, RDATA_RST, "data after reset");
  endtask

  task automatic t_store();
    store_mask(8'hb3);
    rd_chk(1'b1, 8'hbe, "status after store");
    rd_chk(1'b0, RDATA_RST, "data after store");
    host.host_write(1'b1, 8'h0d);
    rd_chk(1'b1, 8'hbe, "status after foreign opcode");
    hold_high(20);
  endtask

  task automatic t_walk();
    logic [7:0] exp_b [3];
    logic [7:0] exp_s [3];
    exp_b = '{8'hc3, 8'h80, 8'h3c};
    exp_s = '{8'hfe, 8'h9e, 8'h2e};
    send_frame(FRAME);
    wait_ready(1'b0, 60);
    rd_chk(1'b0, RDATA_RST, "data first step");
    rd_chk(1'b1, 8'h7e, "status first step");
    for (int k = 0; k < 3; k++) begin
      repeat (3) @(posedge clk_i);
      rd_chk(1'b0, exp_b[k], "extracted byte");
      rd_chk(1'b1, exp_s[k], "step status");
      if (k < 2) `CHK("ready mid walk", 1'b0, extract_ready_n_o)
    end
    wait_ready(1'b1, 20);
  endtask

  task automatic t_clear();
    store_mask(8'h00);
    rd_chk(1'b1, 8'h0e, "status zero mask");
    send_frame(FRAME);
    hold_high(60);
    store_mask(8'hff);
    rd_chk(1'b1, 8'h1e, "status full mask");
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd_chk(1'b1, STAT_RST, "status after pulse");
    rd_chk(1'b0, RDATA_RST, "data after pulse");
    send_frame(FRAME);
    hold_high(60);
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_store();
    t_walk();
    t_clear();
    print_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
endmodule
